// file: design/gpt_timer_set.sv
// Purpose: Standalone 16-bit timer plus a pair joinable into one 32-bit timer
// Assumes: AXI4-Lite register access; idle and sleep come from core logic
// Notes:   Unsynchronised counting keeps running in sleep; synced modes stop
//
// Functional notes
// - Standalone 16-bit timer, sync and async counter modes
// - Standalone flag on period match or gate fall
// - Bit 15 starts and stops counting
// - Bit 13 halts timer during idle
// - Gate accumulation only with internal clock source
// - Prescale field divides by 1, 8, 64, 256
// - Bit 2 selects synced external counting
// - Bit 1 selects external pin rising edges
// - Unimplemented standalone control bits read zero
// - Pair runs as two 16-bit or one 32-bit
// - Lower timer is low word of 32 bits
// - Wide mode uses lower controls, upper flag
// - Upper period is high word; full match
// - Count pair readable anytime, upper is high word
// - Converter trigger only from combined 32-bit pair
// - Both pair counts feed capture/compare time base
// - Standalone timer can run in idle, sleep
// - Wide-mode select sits at lower control bit 3
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
module gpt_timer_set (
   // Clock and reset
   input  wire logic                      i_core_clk,
   input  wire logic                      i_rst_n,
   // Core power state
   input  wire logic                      i_cpu_idle,
   input  wire logic                      i_cpu_sleep,
   // External clock and gate pins
   input  wire logic                      i_standalone_ext_clock_pin,
   input  wire logic                      i_lower_ext_clock_pin,
   input  wire logic                      i_upper_ext_clock_pin,
   // AXI4-Lite write address and data
   input  wire logic [gpt_pkg::ADDR_W-1:0] i_axi_awaddr,
   input  wire logic                      i_axi_awvalid,
   output logic                           o_axi_awready,
   input  wire logic [31:0]               i_axi_wdata,
   input  wire logic [3:0]                i_axi_wstrb,
   input  wire logic                      i_axi_wvalid,
   output logic                           o_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                     o_axi_bresp,
   output logic                           o_axi_bvalid,
   input  wire logic                      i_axi_bready,
   // AXI4-Lite read
   input  wire logic [gpt_pkg::ADDR_W-1:0] i_axi_araddr,
   input  wire logic                      i_axi_arvalid,
   output logic                           o_axi_arready,
   output logic [31:0]                    o_axi_rdata,
   output logic [1:0]                     o_axi_rresp,
   output logic                           o_axi_rvalid,
   input  wire logic                      i_axi_rready,
   // Timer events and time bases
   output logic                           o_standalone_irq_flag,
   output logic                           o_lower_irq_flag,
   output logic                           o_upper_irq_flag,
   output logic                           o_adc_trigger,
   output logic [15:0]                    o_lower_timebase,
   output logic [15:0]                    o_upper_timebase
);
   import gpt_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      logic [2:0][15:0]    ctl;
      logic [2:0][15:0]    per;
      logic [2:0][15:0]    cnt;
      logic [2:0][7:0]     pre;
      logic [2:0]          flag;
      logic                adc;
      logic                aw_full;
      logic                w_full;
      logic [ADDR_W-1:0]   awaddr;
      logic [31:0]         wdata;
      logic [3:0]          wstrb;
      logic                awready;
      logic                wready;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                arready;
      logic                rvalid;
      logic [1:0]          rresp;
      logic [31:0]         rdata;
   } gpt_state_type;

   gpt_state_type st;
   gpt_state_type next_st;

   // ==========================================================
   // Pin synchronisers
   logic [2:0] pin_raw;
   logic [2:0] pin_lvl;
   logic [2:0] pin_rise;
   logic [2:0] pin_fall;

   assign pin_raw = {i_upper_ext_clock_pin, i_lower_ext_clock_pin, i_standalone_ext_clock_pin};

   // One filter per external pin
   for (genvar g = 0; g < 3; g++) begin : g_sync
      gpt_pin_sync u_sync (
         .i_core_clk (i_core_clk),
         .i_rst_n    (i_rst_n),
         .i_pin      (pin_raw[g]),
         .o_level    (pin_lvl[g]),
         .o_rise     (pin_rise[g]),
         .o_fall     (pin_fall[g])
      );
   end

   // ==========================================================
   // Prescaler terminal count for a field value
   function automatic logic [7:0] pre_last(input logic [1:0] sel);
      logic [7:0] r;
      r = PRE_LAST_1;
      unique case (sel)
         2'b11: r = PRE_LAST_256;
         2'b10: r = PRE_LAST_64;
         2'b01: r = PRE_LAST_8;
         2'b00: r = PRE_LAST_1;
      endcase
      return r;
   endfunction

   // Merge a 16-bit write under byte strobes
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      logic [15:0] r;
      r = old;
      if (s[0]) begin
         r[7:0] = d[7:0];
      end
      if (s[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   // ==========================================================
   // Timer datapath and register file
   logic              wide;
   logic [2:0]        tick;
   logic [2:0]        flag_set;
   logic [2:0]        flag_clr;
   logic [15:0]       ec;
   logic              ext_src;
   logic              gated;
   logic              synced;
   logic              halted;
   logic              raw_tick;
   logic [31:0]       c32;
   logic              do_write;
   logic              do_read;
   logic [31:0]       rd_data;
   logic              rd_ok;
   logic              wr_ok;

   always_comb begin
      next_st  = st;
      tick     = '0;
      flag_set = '0;
      flag_clr = '0;
      ec       = '0;
      ext_src  = 1'b0;
      gated    = 1'b0;
      synced   = 1'b1;
      halted   = 1'b0;
      raw_tick = 1'b0;
      c32      = '0;
      rd_data  = '0;
      rd_ok    = 1'b1;
      wr_ok    = 1'b1;
      wide     = st.ctl[1][BIT_WIDE];

      // Prescalers and tick sources; upper unit idles in wide mode
      for (int i = 0; i < 3; i++) begin
         ec       = st.ctl[i];
         ext_src  = ec[BIT_SRC];
         gated    = ec[BIT_GATE] & ~ext_src;
         synced   = (i == 0) ? ec[BIT_SYNC] : 1'b1;
         halted   = (i_cpu_idle & ec[BIT_IDLE])
                  | (i_cpu_sleep & ~(ext_src & ~synced));
         raw_tick = ext_src ? pin_rise[i] : (gated ? pin_lvl[i] : 1'b1);
         if (!ec[BIT_RUN] || (i == 2 && wide)) begin
            next_st.pre[i] = '0;
         end else if (raw_tick && !halted) begin
            if (st.pre[i] == pre_last(ec[BIT_PRE_HI:BIT_PRE_LO])) begin
               next_st.pre[i] = '0;
               tick[i]        = 1'b1;
            end else begin
               next_st.pre[i] = st.pre[i] + 8'h01;
            end
         end
         // Gate falling edge ends an accumulation period
         if (ec[BIT_RUN] && gated && pin_fall[i] && !(i == 2 && wide)) begin
            flag_set[(i == 1 && wide) ? 2 : i] = 1'b1;
         end
      end

      // Counting with period match
      next_st.adc = 1'b0;
      if (wide) begin
         c32 = {st.cnt[2], st.cnt[1]};
         if (tick[1]) begin
            if (c32 == {st.per[2], st.per[1]}) begin
               c32         = '0;
               flag_set[2] = 1'b1;
               next_st.adc = 1'b1;
            end else begin
               c32 = c32 + 32'h0000_0001;
            end
         end
         next_st.cnt[1] = c32[15:0];
         next_st.cnt[2] = c32[31:16];
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (tick[i]) begin
               if (st.cnt[i] == st.per[i]) begin
                  next_st.cnt[i] = '0;
                  flag_set[i]    = 1'b1;
               end else begin
                  next_st.cnt[i] = st.cnt[i] + 16'h0001;
               end
            end
         end
      end

      // Read decode
      unique case (i_axi_araddr)
         OFS_SA_CTL: rd_data = {16'h0000, st.ctl[0]};
         OFS_SA_PER: rd_data = {16'h0000, st.per[0]};
         OFS_SA_CNT: rd_data = {16'h0000, st.cnt[0]};
         OFS_LO_CTL: rd_data = {16'h0000, st.ctl[1]};
         OFS_HI_CTL: rd_data = {16'h0000, st.ctl[2]};
         OFS_LO_PER: rd_data = {16'h0000, st.per[1]};
         OFS_HI_PER: rd_data = {16'h0000, st.per[2]};
         OFS_LO_CNT: rd_data = {16'h0000, st.cnt[1]};
         OFS_HI_CNT: rd_data = {16'h0000, st.cnt[2]};
         OFS_FLAGS:  rd_data = {29'h0000_0000, st.flag};
         default:    rd_ok   = 1'b0;
      endcase

      // Read channel: accept one request, hold data until taken
      do_read = i_axi_arvalid & st.arready;
      if (st.rvalid && i_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (do_read) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = rd_data;
         next_st.rresp  = rd_ok ? RESP_OKAY : RESP_SLV;
      end
      next_st.arready = ~next_st.rvalid;

      // Write channels: latch address and data in either order
      if (i_axi_awvalid && st.awready) begin
         next_st.aw_full = 1'b1;
         next_st.awaddr  = i_axi_awaddr;
      end
      if (i_axi_wvalid && st.wready) begin
         next_st.w_full = 1'b1;
         next_st.wdata  = i_axi_wdata;
         next_st.wstrb  = i_axi_wstrb;
      end
      if (st.bvalid && i_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      do_write = st.aw_full & st.w_full & ~st.bvalid;

      // Control, period and count writes win over the timer update of the same cycle
      if (do_write) begin
         unique case (st.awaddr)
            OFS_SA_CTL: next_st.ctl[0] = merge16(st.ctl[0], st.wdata, st.wstrb) & MASK_SA_CTL;
            OFS_SA_PER: next_st.per[0] = merge16(st.per[0], st.wdata, st.wstrb);
            OFS_SA_CNT: next_st.cnt[0] = merge16(st.cnt[0], st.wdata, st.wstrb);
            OFS_LO_CTL: next_st.ctl[1] = merge16(st.ctl[1], st.wdata, st.wstrb) & MASK_LO_CTL;
            OFS_HI_CTL: next_st.ctl[2] = merge16(st.ctl[2], st.wdata, st.wstrb) & MASK_HI_CTL;
            OFS_LO_PER: next_st.per[1] = merge16(st.per[1], st.wdata, st.wstrb);
            OFS_HI_PER: next_st.per[2] = merge16(st.per[2], st.wdata, st.wstrb);
            OFS_LO_CNT: next_st.cnt[1] = merge16(st.cnt[1], st.wdata, st.wstrb);
            OFS_HI_CNT: next_st.cnt[2] = merge16(st.cnt[2], st.wdata, st.wstrb);
            OFS_FLAGS: begin
               if (st.wstrb[0]) begin
                  flag_clr = st.wdata[2:0];
               end
            end
            default: wr_ok = 1'b0;
         endcase
         next_st.aw_full = 1'b0;
         next_st.w_full  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = wr_ok ? RESP_OKAY : RESP_SLV;
      end
      next_st.awready = ~next_st.aw_full & ~next_st.bvalid;
      next_st.wready  = ~next_st.w_full & ~next_st.bvalid;

      // Sticky flags: a new event beats a clear in the same cycle
      next_st.flag = (st.flag & ~flag_clr) | flag_set;
   end

   // ==========================================================
   // State register
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         st         <= '0;
         st.ctl     <= {3{RST_CTL}};
         st.per     <= {3{RST_PER}};
         st.cnt     <= {3{RST_CNT}};
         st.awready <= 1'b1;
         st.wready  <= 1'b1;
         st.arready <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs, all straight from state
   assign o_axi_awready         = st.awready;
   assign o_axi_wready          = st.wready;
   assign o_axi_bresp           = st.bresp;
   assign o_axi_bvalid          = st.bvalid;
   assign o_axi_arready         = st.arready;
   assign o_axi_rdata           = st.rdata;
   assign o_axi_rresp           = st.rresp;
   assign o_axi_rvalid          = st.rvalid;
   assign o_standalone_irq_flag = st.flag[0];
   assign o_lower_irq_flag      = st.flag[1];
   assign o_upper_irq_flag      = st.flag[2];
   assign o_adc_trigger         = st.adc;
   // Time bases for capture and compare units
   assign o_lower_timebase      = st.cnt[1];
   assign o_upper_timebase      = st.cnt[2];

endmodule

// file: design/gpt_pkg.sv
// Purpose: Constants shared by the general-purpose timer set
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   Timer index 0 is standalone, 1 is the lower pair, 2 the upper pair
package gpt_pkg;

   // ==========================================================
   // Bus geometry and responses
   localparam int             ADDR_W    = 8;
   localparam logic [1:0]     RESP_OKAY = 2'b00;
   localparam logic [1:0]     RESP_SLV  = 2'b10;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0]     OFS_SA_CTL   = 8'h00;
   localparam logic [7:0]     OFS_SA_PER   = 8'h04;
   localparam logic [7:0]     OFS_SA_CNT   = 8'h08;
   localparam logic [7:0]     OFS_LO_CTL   = 8'h0c;
   localparam logic [7:0]     OFS_HI_CTL   = 8'h10;
   localparam logic [7:0]     OFS_LO_PER   = 8'h14;
   localparam logic [7:0]     OFS_HI_PER   = 8'h18;
   localparam logic [7:0]     OFS_LO_CNT   = 8'h1c;
   localparam logic [7:0]     OFS_HI_CNT   = 8'h20;
   localparam logic [7:0]     OFS_FLAGS    = 8'h24;

   // ==========================================================
   // Control field positions
   localparam int             BIT_RUN      = 15;
   localparam int             BIT_IDLE     = 13;
   localparam int             BIT_GATE     = 6;
   localparam int             BIT_PRE_HI   = 5;
   localparam int             BIT_PRE_LO   = 4;
   localparam int             BIT_WIDE     = 3;
   localparam int             BIT_SYNC     = 2;
   localparam int             BIT_SRC      = 1;

   // Implemented bits of each control register
   localparam logic [15:0]    MASK_SA_CTL  = 16'ha076;
   localparam logic [15:0]    MASK_LO_CTL  = 16'ha07a;
   localparam logic [15:0]    MASK_HI_CTL  = 16'ha072;

   // ==========================================================
   // Reset values
   localparam logic [15:0]    RST_CTL      = 16'h0000;
   localparam logic [15:0]    RST_PER      = 16'hffff;
   localparam logic [15:0]    RST_CNT      = 16'h0000;

   // ==========================================================
   // Prescaler terminal counts (ratio minus one)
   localparam logic [7:0]     PRE_LAST_1   = 8'h00;
   localparam logic [7:0]     PRE_LAST_8   = 8'h07;
   localparam logic [7:0]     PRE_LAST_64  = 8'h3f;
   localparam logic [7:0]     PRE_LAST_256 = 8'hff;

endpackage

// file: design/gpt_pin_sync.sv
// Purpose: Three-stage synchroniser with filtered edge detection for a pin
// Assumes: Pin is asynchronous to i_core_clk
// Notes:   A change counts once the second and third stages agree
`timescale 1ns/100ps
module gpt_pin_sync (
   // Clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   // Pin
   input  wire logic i_pin,
   // Filtered level and edges
   output logic      o_level,
   output logic      o_rise,
   output logic      o_fall
);

   typedef struct packed {
      logic [2:0] stage;
      logic       level;
      logic       rise;
      logic       fall;
   } gpt_sync_state_type;

   gpt_sync_state_type st;
   gpt_sync_state_type next_st;

   // ==========================================================
   // Shift chain and agreement filter
   always_comb begin
      next_st       = st;
      next_st.stage = {st.stage[1:0], i_pin};
      if (st.stage[1] == st.stage[2]) begin
         next_st.level = st.stage[2];
      end
      next_st.rise  = next_st.level & ~st.level;
      next_st.fall  = ~next_st.level & st.level;
   end

   // State register
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_level = st.level;
   assign o_rise  = st.rise;
   assign o_fall  = st.fall;

endmodule

// file: bench/gpt_pin_model.sv
// Purpose: Clock and gate pin driver
// Assumes: Pulses slow for the pin filter
// Notes:   Idle pin follows i_level
`timescale 1ns/100ps
module gpt_pin_model (
   // Clock
   input  wire logic       i_core_clk,
   // Burst and idle level
   input  wire logic       i_start,
   input  wire logic [7:0] i_count,
   input  wire logic       i_level,
   // Pin
   output logic            o_pin
);
   logic [7:0] left = 8'h00;
   logic [2:0] ph   = 3'h0;

   initial o_pin = 1'b0;

   // 8-cycle pulses, half high
   always @(posedge i_core_clk) begin
      if (i_start) begin
         left <= i_count;
         ph <= 3'h0;
      end else if (left != 8'h00) begin
         ph <= ph + 3'h1;
         if (ph == 3'h3) o_pin <= #3 1'b1;
         if (ph == 3'h7) begin
            o_pin <= #3 1'b0;
            left <= left - 8'h01;
         end
      end else begin
         o_pin <= #3 i_level;
      end
   end
endmodule

// file: bench/gpt_timer_chk.sv
// Purpose: Port checks of the timer set
// Assumes: Sees top ports only
// Notes:   Bound below
`timescale 1ns/100ps
module gpt_timer_chk
   import gpt_pkg::*;
(
   // Clock and reset
   input wire logic              i_core_clk,
   input wire logic              i_rst_n,
   // Bus
   input wire logic [ADDR_W-1:0] i_axi_araddr,
   input wire logic              i_axi_arvalid,
   input wire logic              o_axi_arready,
   input wire logic              o_axi_rvalid,
   input wire logic              i_axi_rready,
   input wire logic [31:0]       o_axi_rdata,
   input wire logic [1:0]        o_axi_rresp,
   input wire logic              i_axi_awvalid,
   input wire logic              o_axi_awready,
   input wire logic              i_axi_wvalid,
   input wire logic              o_axi_wready,
   input wire logic              o_axi_bvalid,
   input wire logic              i_axi_bready,
   input wire logic [1:0]        o_axi_bresp,
   // Timer outputs
   input wire logic              o_standalone_irq_flag,
   input wire logic              o_lower_irq_flag,
   input wire logic              o_upper_irq_flag,
   input wire logic              o_adc_trigger,
   input wire logic [15:0]       o_lower_timebase,
   input wire logic [15:0]       o_upper_timebase
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   // Bus answers
   a_read_answer: assert property (i_axi_arvalid && o_axi_arready |=> o_axi_rvalid)
      else $error("read late");
   a_read_hold: assert property (o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata))
      else $error("read dropped");
   a_read_refused: assert property (o_axi_rvalid |-> !o_axi_arready)
      else $error("address taken early");
   a_read_unmapped: assert property (i_axi_arvalid && o_axi_arready && i_axi_araddr > OFS_FLAGS
      |=> o_axi_rresp == RESP_SLV)
      else $error("unmapped read ok");
   a_write_answer: assert property (i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready
      |-> ##[1:3] o_axi_bvalid)
      else $error("write late");
   a_write_hold: assert property (o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid && $stable(o_axi_bresp))
      else $error("write dropped");

   // Trigger and flags
   a_trig_pulse: assert property (o_adc_trigger |=> !o_adc_trigger)
      else $error("trigger long");
   a_trig_flag: assert property (o_adc_trigger |-> o_upper_irq_flag)
      else $error("trigger, no flag");
   a_flag_clear: assert property ($fell(o_standalone_irq_flag) || $fell(o_lower_irq_flag)
      || $fell(o_upper_irq_flag) |-> o_axi_bvalid)
      else $error("flag cleared alone");

   // Counts step, wrap or take a write
   a_lower_step: assert property ($changed(o_lower_timebase) |-> o_axi_bvalid
      || o_lower_timebase == 16'h0000 || o_lower_timebase == $past(o_lower_timebase) + 16'h0001)
      else $error("lower jump");
   a_upper_step: assert property ($changed(o_upper_timebase) |-> o_axi_bvalid
      || o_upper_timebase == 16'h0000 || o_upper_timebase == $past(o_upper_timebase) + 16'h0001)
      else $error("upper jump");
endmodule

bind gpt_timer_set gpt_timer_chk i_gpt_timer_chk (
   .i_core_clk, .i_rst_n, .i_axi_araddr, .i_axi_arvalid, .o_axi_arready, .o_axi_rvalid,
   .i_axi_rready, .o_axi_rdata, .o_axi_rresp, .i_axi_awvalid, .o_axi_awready, .i_axi_wvalid,
   .o_axi_wready, .o_axi_bvalid, .i_axi_bready, .o_axi_bresp, .o_standalone_irq_flag,
   .o_lower_irq_flag, .o_upper_irq_flag, .o_adc_trigger, .o_lower_timebase, .o_upper_timebase
);

// file: bench/gp_timer_set_16_32bit_bench.sv
// Purpose: Self-checking timer set bench
// Assumes: Bus driver notes expected answers
// Notes:   Count reads allow a window
`timescale 1ns/100ps
module gp_timer_set_16_32bit_bench;
   import gpt_pkg::*;
   typedef struct packed {logic [31:0] v; logic [31:0] t; logic [1:0] r;} gpt_exp_type;
   localparam logic [15:0] C_RUN = 16'h8000, C_IDL = 16'h2000, C_GAT = 16'h0040;
   localparam logic [15:0] C_WID = 16'h0008, C_SYN = 16'h0004, C_SRC = 16'h0002;
   logic        clk, rst_n, idle, sleep, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, adc;
   logic [7:0]  awaddr, araddr, p_cnt;
   logic [31:0] wdata, rdata, v;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [15:0] lo_tb, hi_tb;
   logic [2:0]  pin, p_start, p_lvl, flags;
   logic [7:0]  ofs[3] = '{OFS_SA_CTL, OFS_LO_CTL, OFS_HI_CTL};
   logic [15:0] msk[3] = '{MASK_SA_CTL, MASK_LO_CTL, MASK_HI_CTL};
   gpt_exp_type rq[$];
   logic [1:0]  wq[$];
   int          err_total, n_compared, cyc, adc_seen, seed, k, r;

   gpt_timer_set i_gpt_timer_set (
      .i_core_clk(clk), .i_rst_n(rst_n), .i_cpu_idle(idle), .i_cpu_sleep(sleep),
      .i_standalone_ext_clock_pin(pin[0]), .i_lower_ext_clock_pin(pin[1]), .i_upper_ext_clock_pin(pin[2]),
      .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid), .o_axi_awready(awready), .i_axi_wdata(wdata),
      .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid), .o_axi_wready(wready), .o_axi_bresp(bresp),
      .o_axi_bvalid(bvalid), .i_axi_bready(bready), .i_axi_araddr(araddr), .i_axi_arvalid(arvalid),
      .o_axi_arready(arready), .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid),
      .i_axi_rready(rready), .o_standalone_irq_flag(flags[0]), .o_lower_irq_flag(flags[1]),
      .o_upper_irq_flag(flags[2]), .o_adc_trigger(adc), .o_lower_timebase(lo_tb), .o_upper_timebase(hi_tb));

   // Pin drivers
   for (genvar g = 0; g < 3; g++) begin : g_pin
      gpt_pin_model i_gpt_pin_model (.i_core_clk(clk), .i_start(p_start[g]), .i_count(p_cnt),
         .i_level(p_lvl[g]), .o_pin(pin[g]));
   end

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task stop_test();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Write, noting the response
   task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] rs = RESP_OKAY);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      wq.push_back(rs);
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
   endtask

   // Read, noting value, window and response
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] t = 0,
           input logic [1:0] rs = RESP_OKAY);
      araddr <= a;
      arvalid <= 1'b1;
      rq.push_back(gpt_exp_type'{e, t, rs});
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
   endtask

   // Run standalone timer w cycles
   task meas(input logic [15:0] c, input int w);
      wr(OFS_SA_CNT, 16'h0000);
      wr(OFS_SA_CTL, c);
      repeat (w) @(posedge clk);
      wr(OFS_SA_CTL, 16'h0000);
   endtask

   // Count pin pulses
   task ext(input logic [15:0] c, input logic s, input logic [31:0] n);
      sleep <= s;
      wr(OFS_SA_CNT, 16'h0000);
      wr(OFS_SA_CTL, c);
      p_start[0] <= 1'b1;
      @(posedge clk);
      p_start[0] <= 1'b0;
      repeat (200) @(posedge clk);
      sleep <= 1'b0;
      rd(OFS_SA_CNT, n);
   endtask

   task waitf(input int i);
      for (int n = 0; n < 3000 && flags[i] !== 1'b1; n++) @(posedge clk);
   endtask

   // Compare answers with the oldest notes
   always @(posedge clk) begin : mon
      gpt_exp_type e;
      if (adc === 1'b1) adc_seen++;
      if (rst_n && bvalid && bready) check({30'h0, bresp}, {30'h0, wq.pop_front()});
      if (rst_n && rvalid && rready) begin
         e = rq.pop_front();
         check((rdata + e.t >= e.v && rdata <= e.v + e.t) ? e.v : rdata, e.v);
         check({30'h0, rresp}, {30'h0, e.r});
      end
   end

   // Watchdog
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         stop_test();
      end
   end

   initial begin
      {rst_n, idle, sleep, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
      {p_start, p_lvl, err_total, n_compared, cyc, adc_seen} = '0;
      {bready, rready, wstrb, p_cnt, seed} = {1'b1, 1'b1, 4'hf, 8'd20, 18351};
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(OFS_SA_CTL, 0);
      rd(OFS_LO_PER, 32'h0000ffff);
      rd(OFS_HI_CNT, 0);
      rd(8'h28, 0, 0, RESP_SLV);
      wr(8'h28, 16'h1234, RESP_SLV);
      for (k = 0; k < 3; k++) begin
         wr(ofs[k], 16'hffff);
         rd(ofs[k], {16'h0, msk[k]});
         wr(ofs[k], 16'h0000);
         v = $random(seed);
         wr(OFS_HI_PER, v[15:0]);
         rd(OFS_HI_PER, {16'h0, v[15:0]});
      end
      $display("test registers done");
      wr(OFS_SA_PER, 16'hffff);
      for (k = 0; k < 4; k++) begin
         r = (k == 3) ? 256 : (1 << (3 * k));
         meas(C_RUN | {10'h0, k[1:0], 4'h0}, 100 * r);
         rd(OFS_SA_CNT, (r == 1) ? 104 : 100, 4);
      end
      $display("test prescale done");
      idle <= 1'b1;
      meas(C_RUN | C_IDL, 100);
      rd(OFS_SA_CNT, 0);
      meas(C_RUN, 100);
      rd(OFS_SA_CNT, 104, 4);
      idle <= 1'b0;
      ext(C_RUN | C_SRC, 1'b1, 20);
      ext(C_RUN | C_SRC | C_SYN, 1'b1, 0);
      ext(C_RUN | C_SRC | C_SYN, 1'b0, 20);
      ext(C_RUN | C_SRC | C_GAT, 1'b0, 20);
      $display("test modes done");
      meas(C_RUN | C_GAT, 100);
      rd(OFS_SA_CNT, 0);
      p_lvl[0] <= 1'b1;
      repeat (20) @(posedge clk);
      wr(OFS_FLAGS, 16'h0007);
      wr(OFS_SA_CNT, 16'h0000);
      wr(OFS_SA_CTL, C_RUN | C_GAT);
      repeat (100) @(posedge clk);
      p_lvl[0] <= 1'b0;
      repeat (20) @(posedge clk);
      rd(OFS_SA_CNT, 105, 5);
      rd(OFS_FLAGS, 1);
      wr(OFS_FLAGS, 16'h0007);
      rd(OFS_FLAGS, 0);
      wr(OFS_SA_PER, 16'h0004);
      wr(OFS_SA_CNT, 16'h0000);
      wr(OFS_SA_CTL, C_RUN);
      waitf(0);
      wr(OFS_SA_CTL, 16'h0000);
      rd(OFS_FLAGS, 1);
      rd(OFS_SA_CNT, 2, 2);
      $display("test gate and match done");
      wr(OFS_LO_PER, 16'h0003);
      wr(OFS_LO_CTL, C_RUN);
      waitf(1);
      wr(OFS_HI_PER, 16'h0003);
      wr(OFS_HI_CTL, C_RUN);
      waitf(2);
      wr(OFS_LO_CTL, 16'h0000);
      wr(OFS_HI_CTL, 16'h0030);
      rd(OFS_FLAGS, 7);
      check(adc_seen, 0);
      wr(OFS_FLAGS, 16'h0007);
      wr(OFS_LO_CNT, 16'hfffe);
      wr(OFS_HI_CNT, 16'h0000);
      wr(OFS_LO_PER, 16'h0002);
      wr(OFS_HI_PER, 16'h0001);
      wr(OFS_LO_CTL, C_RUN | C_WID);
      waitf(2);
      wr(OFS_LO_CTL, 16'h0000);
      rd(OFS_FLAGS, 4);
      check(adc_seen, 1);
      wr(OFS_FLAGS, 16'h0007);
      wr(OFS_LO_PER, 16'hffff);
      wr(OFS_HI_PER, 16'hffff);
      wr(OFS_LO_CNT, 16'hfff0);
      wr(OFS_HI_CNT, 16'h0000);
      wr(OFS_LO_CTL, C_RUN | C_WID);
      repeat (100) @(posedge clk);
      wr(OFS_LO_CTL, 16'h0000);
      rd(OFS_HI_CNT, 1);
      rd(OFS_LO_CNT, 32'h58, 6);
      check({16'h0, hi_tb}, 1);
      check({16'h0, lo_tb} & 32'hfff0, 32'h50);
      $display("test pair done");
      stop_test();
   end
endmodule
